/* aal_cfg.svh */
// aal_cfg.svh: constants for the accumulator add / logic unit
// assumes inclusion by the package and the unit; definitions only
`ifndef AAL_CFG_SVH
`define AAL_CFG_SVH
`define AAL_ACC_W        36
`define AAL_WORD_W       16
`define AAL_SIGN_BIT     35
`define AAL_UPPER_MSB    31
`define AAL_UPPER_LSB    16
`define AAL_IMM5_W       5
// status word flag positions
`define AAL_FLAG_C       0
`define AAL_FLAG_V       1
`define AAL_FLAG_Z       2
`define AAL_FLAG_N       3
`define AAL_FLAG_U       4
`define AAL_FLAG_E       5
`define AAL_FLAG_L       6
`define AAL_SR_RESET     16'h0000
// cycle counts per operand form
`define AAL_CYC_REG      4'h2
`define AAL_CYC_SHORT    4'h4
`define AAL_CYC_LONG     4'h6
`define AAL_CYC_RMW_S    4'h6
`define AAL_CYC_RMW_L    4'h8
// register port offsets
`define AAL_OFF_STATUS   4'h0
`define AAL_OFF_ACC_EXT  4'h1
`define AAL_OFF_ACC_HI   4'h2
`define AAL_OFF_ACC_LO   4'h3
`endif

/* aal_pkg.sv */
// aal_pkg.sv: types of the accumulator add / logic unit
// assumes aal_cfg.svh is on the include path
`include "aal_cfg.svh"
package aal_pkg;
    // operation selector
    typedef enum logic [3:0] {
        AAL_OP_ADD_REG,     // 36-bit register add
        AAL_OP_ADD_WORD_REG,// 16-bit register word add
        AAL_OP_ADD_MEM_SP,  // memory word, stack relative
        AAL_OP_ADD_MEM_AA,  // memory word, short absolute
        AAL_OP_ADD_MEM_ABS, // memory word, long absolute
        AAL_OP_ADDM_SP,     // register into memory, stack relative
        AAL_OP_ADDM_ABS,    // register into memory, long absolute
        AAL_OP_ADDM_AA,     // register into memory, short absolute
        AAL_OP_ADD_IMM5,    // unsigned 0..31 immediate
        AAL_OP_ADD_IMM16,   // signed 16-bit immediate
        AAL_OP_ADD_MOVE,    // add with parallel move
        AAL_OP_AND,         // 16-bit logical and
        AAL_OP_IMMEDIATE_MASK_AND         // immediate and (bit-field clear)
    } aal_op_e;
    typedef enum logic [1:0] {AAL_ST_IDLE, AAL_ST_READ, AAL_ST_EXEC, AAL_ST_WRITE} aal_state_e;
    // one instruction request
    typedef struct packed {
        aal_op_e     op;
        logic [35:0] src;          // 36-bit source or 16-bit word in [15:0]
        logic [15:0] imm;          // immediate or bit mask source
        logic        to_status;    // immediate and aimed at the status word
        logic        move_limited; // limiting seen in the parallel / source move
        logic [3:0]  move_cycles;  // parallel move overhead
    } aal_req_s;
    // memory read-modify-write port
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] wdata;
    } aal_mem_s;
endpackage

/* aal_unit.sv */
// aal_unit.sv: add, logical and and immediate and over one accumulator
// assumes one 125 MHz clock, sync reset, requests from the decoder on the same clock
// Notes on behaviour
// - move limiting or overflow sets limit flag
// - extension in use sets extension flag
// - negative from bit 35 unless saturated
// - zero flag when whole result zero
// - overflow flag on add overflow
// - carry from bit 35 sets carry
// - register add: 2 cycles, one word
// - memory add: 6, 4, 6 cycles
// - add into memory: 8 or 6 cycles
// - unsigned 0..31 immediate add in 4
// - signed 16-bit immediate add in 6
// - add with move: 2 plus move
// - and touches only bits 31-16
// - and negative flag from bit 31
// - and zero flag on bits 31-16
// - register and takes 2 cycles
// - immediate and clears with inverted mask
// - immediate and reads then writes destination
// - carry set when all masked bits of a memory destination set
// - limit flag on 36-bit source limiting
// - word operand added at upper word
`timescale 1ns/1ps
`include "aal_cfg.svh"
module aal_unit
    import aal_pkg::*;
(
    input  wire logic        mclk_in,
    input  wire logic        rstn_in,
    input  wire aal_req_s    req_in,
    input  wire logic        req_valid_in,
    input  wire logic [15:0] mem_rdata_in,
    input  wire logic        mem_rdata_valid_in,
    input  wire logic [3:0]  reg_addr_in,
    input  wire logic [15:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output aal_mem_s         mem_out,
    output logic [15:0]      reg_rdata_out,
    output logic             busy_out,
    output logic             done_out
);
    aal_state_e  state_ff, nxt_state;
    logic [35:0] acc_ff, nxt_acc;
    logic [15:0] status_word_ff, nxt_status_word;
    logic [3:0]  cnt_ff, nxt_cnt;
    aal_req_s    req_ff, nxt_req;
    logic [15:0] mem_word_ff, nxt_mem_word;
    aal_mem_s    mem_ff, nxt_mem;
    logic        done_ff, nxt_done;
    logic [15:0] rdata_ff, nxt_rdata;
    logic        busy_ff, nxt_busy;

    // operand shaping
    logic [35:0] opnd;
    logic [36:0] sum;
    logic [35:0] res;
    logic        ovf, sat;
    logic [15:0] and_hi, clr_mask, cleared;
    logic        is_mem, is_rmw;

    // word sources land on the upper word, sign extended into the extension
    always_comb begin
        is_mem = (req_ff.op == AAL_OP_ADD_MEM_SP) || (req_ff.op == AAL_OP_ADD_MEM_AA) ||
                 (req_ff.op == AAL_OP_ADD_MEM_ABS);
        is_rmw = (req_ff.op == AAL_OP_ADDM_SP) || (req_ff.op == AAL_OP_ADDM_ABS) ||
                 (req_ff.op == AAL_OP_ADDM_AA);
        unique case (req_ff.op)
            AAL_OP_ADD_REG, AAL_OP_ADD_MOVE:
                opnd = req_ff.src;
            AAL_OP_ADD_IMM5:
                opnd = {15'h0000, req_ff.imm[`AAL_IMM5_W-1:0], 16'h0000};
            AAL_OP_ADD_IMM16:
                opnd = {{4{req_ff.imm[15]}}, req_ff.imm, 16'h0000};
            AAL_OP_ADD_MEM_SP, AAL_OP_ADD_MEM_AA, AAL_OP_ADD_MEM_ABS:
                opnd = {{4{mem_word_ff[15]}}, mem_word_ff, 16'h0000};
            default:
                opnd = {{4{req_ff.src[15]}}, req_ff.src[15:0], 16'h0000};
        endcase
    end

    // 36-bit adder; the memory-destination form adds to the word read back
    always_comb begin
        if (is_rmw) begin
            sum = {1'b0, {{4{mem_word_ff[15]}}, mem_word_ff, 16'h0000}}
                + {1'b0, {{4{req_ff.src[15]}}, req_ff.src[15:0], 16'h0000}};
        end else begin
            sum = {1'b0, acc_ff} + {1'b0, opnd};
        end
        ovf = (acc_ff[`AAL_SIGN_BIT] == opnd[`AAL_SIGN_BIT]) &&
              (sum[`AAL_SIGN_BIT] != acc_ff[`AAL_SIGN_BIT]);
        if (is_rmw) begin
            ovf = (mem_word_ff[15] == req_ff.src[15]) && (sum[`AAL_SIGN_BIT] != mem_word_ff[15]);
        end
        res = sum[35:0];
        sat = 1'b0; // no saturation mode is modelled, so the add result is never saturated
        and_hi = acc_ff[`AAL_UPPER_MSB:`AAL_UPPER_LSB] & req_ff.src[15:0];
        clr_mask = ~req_ff.imm;
        cleared = mem_word_ff & ~clr_mask;
    end

    // sequencer, accumulator and status word
    always_comb begin
        nxt_state = state_ff;
        nxt_acc = acc_ff;
        nxt_status_word = status_word_ff;
        nxt_cnt = cnt_ff;
        nxt_req = req_ff;
        nxt_mem_word = mem_word_ff;
        nxt_mem = '0;
        nxt_done = 1'b0;
        nxt_rdata = 16'h0000;
        unique case (state_ff)
            AAL_ST_IDLE: begin
                if (req_valid_in) begin
                    nxt_req = req_in;
                    // total cycles, counted down to 2 at completion
                    unique case (req_in.op)
                        AAL_OP_ADD_MEM_SP, AAL_OP_ADD_MEM_ABS: nxt_cnt = `AAL_CYC_LONG;
                        AAL_OP_ADD_MEM_AA:                     nxt_cnt = `AAL_CYC_SHORT;
                        AAL_OP_ADDM_SP, AAL_OP_ADDM_ABS:       nxt_cnt = `AAL_CYC_RMW_L;
                        AAL_OP_ADDM_AA:                        nxt_cnt = `AAL_CYC_RMW_S;
                        AAL_OP_ADD_IMM5:                       nxt_cnt = `AAL_CYC_SHORT;
                        AAL_OP_ADD_IMM16:                      nxt_cnt = `AAL_CYC_LONG;
                        AAL_OP_ADD_MOVE:
                            nxt_cnt = 4'(`AAL_CYC_REG + req_in.move_cycles);
                        AAL_OP_IMMEDIATE_MASK_AND:                           nxt_cnt = `AAL_CYC_SHORT;
                        default:                               nxt_cnt = `AAL_CYC_REG;
                    endcase
                    if ((req_in.op == AAL_OP_IMMEDIATE_MASK_AND && !req_in.to_status) ||
                        req_in.op == AAL_OP_ADD_MEM_SP || req_in.op == AAL_OP_ADD_MEM_AA ||
                        req_in.op == AAL_OP_ADD_MEM_ABS || req_in.op == AAL_OP_ADDM_SP ||
                        req_in.op == AAL_OP_ADDM_ABS || req_in.op == AAL_OP_ADDM_AA) begin
                        nxt_mem.rd = 1'b1;
                        nxt_state = AAL_ST_READ;
                    end else begin
                        if (req_in.op == AAL_OP_IMMEDIATE_MASK_AND) begin
                            nxt_mem_word = status_word_ff;
                        end
                        nxt_state = AAL_ST_EXEC;
                    end
                end
            end
            AAL_ST_READ: begin
                nxt_cnt = cnt_ff - 4'h1;
                if (mem_rdata_valid_in) begin
                    nxt_mem_word = mem_rdata_in;
                    nxt_state = AAL_ST_EXEC;
                end
            end
            AAL_ST_EXEC: begin
                if (cnt_ff > `AAL_CYC_REG) begin
                    nxt_cnt = cnt_ff - 4'h1; // pad to the documented count
                end else begin
                    nxt_state = AAL_ST_IDLE;
                    nxt_done = 1'b1;
                    unique case (req_ff.op)
                        AAL_OP_AND: begin
                            nxt_acc[`AAL_UPPER_MSB:`AAL_UPPER_LSB] = and_hi;
                            nxt_status_word[`AAL_FLAG_N] = and_hi[15];
                            nxt_status_word[`AAL_FLAG_Z] = (and_hi == 16'h0000);
                            nxt_status_word[`AAL_FLAG_V] = 1'b0;
                        end
                        AAL_OP_IMMEDIATE_MASK_AND: begin
                            if (req_ff.to_status) begin
                                nxt_status_word = cleared; // status word is its own target
                            end else begin
                                nxt_mem = '{rd: 1'b0, wr: 1'b1, wdata: cleared};
                                nxt_status_word[`AAL_FLAG_C] = ((mem_word_ff & clr_mask) == clr_mask);
                                nxt_status_word[`AAL_FLAG_L] = status_word_ff[`AAL_FLAG_L] | req_ff.move_limited;
                            end
                        end
                        default: begin
                            if (is_rmw) begin
                                nxt_mem = '{rd: 1'b0, wr: 1'b1, wdata: res[31:16]};
                            end else begin
                                nxt_acc = res;
                            end
                            // limit is sticky: set by move limiting or overflow
                            nxt_status_word[`AAL_FLAG_L] = status_word_ff[`AAL_FLAG_L] | ovf |
                                (req_ff.op == AAL_OP_ADD_MOVE && req_ff.move_limited);
                            nxt_status_word[`AAL_FLAG_E] =
                                !((res[35:31] == 5'h00) || (res[35:31] == 5'h1f));
                            if (!sat) begin
                                nxt_status_word[`AAL_FLAG_N] = res[`AAL_SIGN_BIT];
                            end
                            nxt_status_word[`AAL_FLAG_Z] = (res == 36'h0);
                            nxt_status_word[`AAL_FLAG_V] = ovf;
                            nxt_status_word[`AAL_FLAG_C] = sum[`AAL_ACC_W];
                            nxt_status_word[`AAL_FLAG_U] = !(res[31] ^ res[30]);
                        end
                    endcase
                end
            end
            default: begin
                nxt_state = AAL_ST_IDLE;
            end
        endcase
        // software access; an instruction finishing this cycle wins over a write
        if (reg_wr_in && !nxt_done) begin
            unique case (reg_addr_in)
                `AAL_OFF_STATUS:  nxt_status_word = reg_wdata_in;
                `AAL_OFF_ACC_EXT: nxt_acc[35:32] = reg_wdata_in[3:0];
                `AAL_OFF_ACC_HI:  nxt_acc[31:16] = reg_wdata_in;
                `AAL_OFF_ACC_LO:  nxt_acc[15:0] = reg_wdata_in;
                default: ;
            endcase
        end
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                `AAL_OFF_STATUS:  nxt_rdata = status_word_ff;
                `AAL_OFF_ACC_EXT: nxt_rdata = {12'h000, acc_ff[35:32]};
                `AAL_OFF_ACC_HI:  nxt_rdata = acc_ff[31:16];
                `AAL_OFF_ACC_LO:  nxt_rdata = acc_ff[15:0];
                default:          nxt_rdata = 16'h0000;
            endcase
        end
        // busy follows the next state so the port can leave from a flop
        nxt_busy = (nxt_state != AAL_ST_IDLE);
    end

    // sequencer state; the request is held for the whole operation
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            state_ff    <= AAL_ST_IDLE;
            cnt_ff      <= 4'h0;
            req_ff      <= '0;
            mem_word_ff <= 16'h0000;
        end else begin
            state_ff    <= nxt_state;
            cnt_ff      <= nxt_cnt;
            req_ff      <= nxt_req;
            mem_word_ff <= nxt_mem_word;
        end
    end

    // architectural state: accumulator and status word
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            acc_ff         <= 36'h0;
            status_word_ff <= `AAL_SR_RESET;
        end else begin
            acc_ff         <= nxt_acc;
            status_word_ff <= nxt_status_word;
        end
    end

    // port registers; every output leaves straight from one of these
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            mem_ff   <= '0;
            done_ff  <= 1'b0;
            rdata_ff <= 16'h0000;
            busy_ff  <= 1'b0;
        end else begin
            mem_ff   <= nxt_mem;
            done_ff  <= nxt_done;
            rdata_ff <= nxt_rdata;
            busy_ff  <= nxt_busy;
        end
    end

    assign mem_out       = mem_ff;
    assign reg_rdata_out = rdata_ff;
    assign done_out      = done_ff;
    assign busy_out      = busy_ff;
endmodule

/* aal_unit_properties.sv */
// aal_unit_properties.sv: port-level checks of the add / logic unit
// assumes a bind onto aal_unit and a memory that answers the cycle after a read
`timescale 1ns/1ps
module aal_unit_props
    import aal_pkg::*;
(
    input wire logic        mclk_in,
    input wire logic        rstn_in,
    input wire aal_req_s    req_in,
    input wire logic        req_valid_in,
    input wire logic [15:0] mem_rdata_in,
    input wire logic        mem_rdata_valid_in,
    input wire logic [3:0]  reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic        reg_wr_in,
    input wire logic        reg_rd_in,
    input wire aal_mem_s    mem_out,
    input wire logic [15:0] reg_rdata_out,
    input wire logic        busy_out,
    input wire logic        done_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);
    // a request is taken only while idle
    logic tk;
    assign tk = req_valid_in && !busy_out;
    property p_lat_reg;
        tk && req_in.op == AAL_OP_ADD_REG |=> !done_out ##1 done_out;
    endproperty
    a_lat_reg: assert property (p_lat_reg) else $error("register add latency wrong");
    property p_lat_and;
        tk && req_in.op == AAL_OP_AND |=> !done_out ##1 done_out;
    endproperty
    a_lat_and: assert property (p_lat_and) else $error("register and latency wrong");
    property p_lat_imm5;
        tk && req_in.op == AAL_OP_ADD_IMM5 |=> !done_out[*3] ##1 done_out;
    endproperty
    a_lat_imm5: assert property (p_lat_imm5) else $error("short immediate latency wrong");
    property p_lat_imm16;
        tk && req_in.op == AAL_OP_ADD_IMM16 |=> !done_out[*5] ##1 done_out;
    endproperty
    a_lat_imm16: assert property (p_lat_imm16) else $error("long immediate latency wrong");
    property p_lat_mem;
        tk && req_in.op == AAL_OP_ADD_MEM_AA |=> !done_out[*3] ##1 done_out;
    endproperty
    a_lat_mem: assert property (p_lat_mem) else $error("short address add latency wrong");
    property p_lat_rmw;
        tk && req_in.op == AAL_OP_ADDM_SP |=> !done_out[*7] ##1 done_out;
    endproperty
    a_lat_rmw: assert property (p_lat_rmw) else $error("add into memory latency wrong");
    property p_immediate_mask_and_rmw;
        tk && req_in.op == AAL_OP_IMMEDIATE_MASK_AND && !req_in.to_status |=> mem_out.rd ##1 !mem_out.rd ##[1:4] mem_out.wr;
    endproperty
    a_immediate_mask_and_rmw: assert property (p_immediate_mask_and_rmw) else $error("immediate and skipped read or write");
    property p_busy_take;
        tk |=> busy_out;
    endproperty
    a_busy_take: assert property (p_busy_take) else $error("busy not raised on request");
    property p_done_free;
        $fell(busy_out) |-> done_out && !$past(done_out);
    endproperty
    a_done_free: assert property (p_done_free) else $error("busy fell without done pulse");
    property p_rdata_idle;
        !$past(reg_rd_in) |-> reg_rdata_out == 16'h0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
    c_move: cover property (tk && req_in.op == AAL_OP_ADD_MOVE);
    c_wr: cover property (mem_out.wr && done_out);
    c_b2b: cover property (done_out ##1 busy_out);
endmodule

/* aal_unit_tb.sv */
// aal_unit_tb.sv: self-checking bench of the add / logic unit
// assumes aal_pkg, aal_unit and aal_unit_props compiled before it
`timescale 1ns/1ps
module aal_unit_tb;
    import aal_pkg::*;
    logic        mclk_in = 0, rstn_in = 0, req_valid_in = 0, mem_rdata_valid_in = 0;
    logic        reg_wr_in = 0, reg_rd_in = 0, rd_prev = 0, busy_out, done_out;
    aal_req_s    req_in = '0;
    aal_mem_s    mem_out;
    logic [3:0]  reg_addr_in = '0;
    logic [15:0] mem_rdata_in = '0, reg_wdata_in = '0, mem_word = '0, reg_rdata_out, st;
    logic [15:0] q_rd[$], q_mk[$], q_wr[$];
    logic [35:0] acc;
    logic [31:0] seed = 32'h8f7a;
    int          q_lat[$];
    int          num_errors = 0, compares = 0, cyc = 0, t0 = 0;
    int          lat[13] = '{2, 2, 6, 4, 6, 8, 8, 6, 4, 6, 0, 2, 4};
    always #4 mclk_in = ~mclk_in;
    aal_unit aal_unit_i (.mclk_in, .rstn_in, .req_in, .req_valid_in, .mem_rdata_in, .mem_rdata_valid_in,
        .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .mem_out, .reg_rdata_out, .busy_out, .done_out);
    // memory answers next cycle; between answers the bus toggles so stale data never matches
    always @(posedge mclk_in) begin
        mem_rdata_valid_in <= mem_out.rd;
        mem_rdata_in <= mem_out.rd ? mem_word : ~mem_rdata_in;
    end
    function automatic logic [15:0] rnd();
        repeat (16) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[15:0];
    endfunction
    function automatic logic [35:0] wx(input logic [15:0] v);
        return {{4{v[15]}}, v, 16'h0000};
    endfunction
    task automatic chk(input string nm, input logic [15:0] e, g, m);
        compares++;
        if ((g & m) !== (e & m)) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, e & m, g & m);
        end
    endtask
    // watcher samples mid-cycle and takes the oldest note whenever a result shows
    always @(negedge mclk_in) begin
        cyc++;
        if (rd_prev) chk("reg_rdata_out", q_rd.pop_front(), reg_rdata_out, q_mk.pop_front());
        if (done_out) chk("latency", 16'(q_lat.pop_front()), 16'(cyc - t0), 16'hffff);
        if (mem_out.wr)
            chk("mem_wdata", q_wr.size() > 0 ? q_wr.pop_front() : ~mem_out.wdata, mem_out.wdata, 16'hffff);
        if (req_valid_in && !busy_out) t0 = cyc;
        rd_prev = reg_rd_in;
    end
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge mclk_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e, m);
        @(posedge mclk_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        q_rd.push_back(e);
        q_mk.push_back(m);
        @(posedge mclk_in);
        reg_rd_in <= 1'b0;
    endtask
    task automatic check_all(input logic [15:0] sm);
        rd(4'h0, st, sm);
        rd(4'h1, {12'h000, acc[35:32]}, 16'hffff);
        rd(4'h2, acc[31:16], 16'hffff);
        rd(4'h3, acc[15:0], 16'hffff);
    endtask
    // request held until the taking edge, then scrambled so late sampling shows
    task automatic op(input aal_req_s r, input int n);
        @(posedge mclk_in);
        req_in <= r;
        req_valid_in <= 1'b1;
        q_lat.push_back(n);
        @(posedge mclk_in);
        req_valid_in <= 1'b0;
        req_in <= ~r;
        @(negedge mclk_in);
        for (int i = 0; i < 40 && done_out !== 1'b1; i++) @(negedge mclk_in);
    endtask
    task automatic add_model(input logic [35:0] b, input logic lim);
        logic [36:0] s;
        s = {1'b0, acc} + {1'b0, b};
        st[0] = s[36];
        st[1] = (acc[35] == b[35]) && (s[35] != acc[35]);
        st[2] = s[35:0] == 36'h0;
        st[3] = s[35];
        st[4] = ~(s[31] ^ s[30]);
        st[5] = !(&s[35:31] || ~|s[35:31]);
        st[6] = st[6] | st[1] | lim;
        acc = s[35:0];
    endtask
    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #50000;
        num_errors++;
        wrap_up();
    end
    initial begin
        aal_req_s    r;
        aal_op_e     o;
        logic [15:0] w, m;
        logic [35:0] keep;
        acc = '0;
        st = '0;
        repeat (10) @(posedge mclk_in);
        rstn_in <= 1'b1;
        check_all(16'hffff);
        rd(4'h9, 16'h0000, 16'hffff);
        // two passes over every operation; the second aims immediate and at the status word
        for (int k = 0; k < 26; k++) begin
            o = aal_op_e'(k % 13);
            w = rnd();
            acc = {w[3:0], rnd(), rnd()};
            wr(4'h1, {12'h000, acc[35:32]});
            wr(4'h2, acc[31:16]);
            wr(4'h3, acc[15:0]);
            st = rnd() & 16'h007f;
            wr(4'h0, st);
            mem_word = rnd();
            r = '{o, {w[7:4], rnd(), rnd()}, rnd(), k > 12, w[9] && (o == AAL_OP_ADD_MOVE || o == AAL_OP_IMMEDIATE_MASK_AND),
                  4'(w[11:10])};
            if (k == 13) r.src = ~acc + 36'h1;
            if (k == 24) r.src = '0;
            m = 16'hffff;
            case (o)
                AAL_OP_ADD_REG, AAL_OP_ADD_MOVE: add_model(r.src, r.move_limited);
                AAL_OP_ADD_WORD_REG: add_model(wx(r.src[15:0]), 1'b0);
                AAL_OP_ADD_MEM_SP, AAL_OP_ADD_MEM_AA, AAL_OP_ADD_MEM_ABS: add_model(wx(mem_word), 1'b0);
                AAL_OP_ADD_IMM5: add_model(wx({11'h000, r.imm[4:0]}), 1'b0);
                AAL_OP_ADD_IMM16: add_model(wx(r.imm), 1'b0);
                AAL_OP_AND: begin
                    acc[31:16] = acc[31:16] & r.src[15:0];
                    st[3] = acc[31];
                    st[2] = acc[31:16] == 16'h0000;
                    st[1] = 1'b0;
                    m = 16'h000e;
                end
                AAL_OP_IMMEDIATE_MASK_AND: begin
                    if (r.to_status) begin
                        st = st & r.imm;
                    end else begin
                        q_wr.push_back(mem_word & r.imm);
                        st[0] = (mem_word | r.imm) == 16'hffff;
                        st[6] = st[6] | r.move_limited;
                        m = 16'h0041;
                    end
                end
                AAL_OP_ADDM_SP, AAL_OP_ADDM_ABS, AAL_OP_ADDM_AA: begin
                    keep = acc;
                    acc = wx(mem_word);
                    add_model(wx(r.src[15:0]), 1'b0);
                    q_wr.push_back(acc[31:16]);
                    acc = keep;
                end
                default: m = 16'h0000;
            endcase
            op(r, o == AAL_OP_ADD_MOVE ? 2 + int'(r.move_cycles) : lat[k % 13]);
            check_all(m);
        end
        repeat (3) @(posedge mclk_in);
        chk("pending_notes", 16'h0000, 16'(q_lat.size() + q_wr.size() + q_rd.size()), 16'hffff);
        wrap_up();
    end
endmodule
bind aal_unit aal_unit_props aal_unit_props_i (.mclk_in, .rstn_in, .req_in, .req_valid_in, .mem_rdata_in,
    .mem_rdata_valid_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .mem_out, .reg_rdata_out,
    .busy_out, .done_out);
